// ==== common/tmr_pkg.sv ====
// tmr_pkg: constants, mode codes and carrier structs for the 16-bit timer
// assumes: included before every tmr_ design file; no imports are used
package tmr_pkg;
   // ------------------------------------------------------------
   // register map (word offsets in bytes)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_COUNT = 4'h4;
   localparam logic [3:0] ADDR_CMPA = 4'h8;
   localparam logic [3:0] ADDR_CMPB = 4'hC;
   localparam logic [4:0] ADDR_CAPT = 5'h10;
   localparam logic [4:0] ADDR_FLAGS = 5'h14;
   localparam logic [4:0] ADDR_LAST = 5'h14;
   // ------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ACTA_LSB = 4;
   localparam int CTRL_ACTB_LSB = 6;
   localparam int CTRL_PRE_LSB = 8;
   localparam int CTRL_DIRA_BIT = 11;
   localparam int CTRL_DIRB_BIT = 12;
   localparam int CTRL_FORCEA_BIT = 13;
   localparam int CTRL_FORCEB_BIT = 14;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ------------------------------------------------------------
   // flag positions
   // ------------------------------------------------------------
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMPA_BIT = 1;
   localparam int FLAG_CMPB_BIT = 2;
   localparam int FLAG_CAPT_BIT = 3;
   // ------------------------------------------------------------
   // counter values
   // ------------------------------------------------------------
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   // ------------------------------------------------------------
   // prescaler divides
   // ------------------------------------------------------------
   localparam logic [10:0] DIV_8 = 11'h008;
   localparam logic [10:0] DIV_64 = 11'h040;
   localparam logic [10:0] DIV_256 = 11'h100;
   localparam logic [10:0] DIV_1024 = 11'h400;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      WGM_NORMAL = 4'b0000,
      WGM_CTC_CMPA = 4'b0100,
      WGM_FAST8 = 4'b0101,
      WGM_FAST9 = 4'b0110,
      WGM_FAST10 = 4'b0111,
      WGM_CTC_CAPT = 4'b1100,
      WGM_FAST_CAPT = 4'b1110,
      WGM_FAST_CMPA = 4'b1111
   } tmr_wgm_e;
   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR = 2'b10,
      ACT_SET = 2'b11
   } tmr_act_e;
   typedef enum logic [2:0] {
      PRE_STOP = 3'b000,
      PRE_DIV1 = 3'b001,
      PRE_DIV8 = 3'b010,
      PRE_DIV64 = 3'b011,
      PRE_DIV256 = 3'b100,
      PRE_DIV1024 = 3'b101
   } tmr_pre_e;
   typedef struct packed {
      logic [3:0] waveform_mode_select;
      logic [1:0] compare_a_output_action;
      logic [1:0] compare_b_output_action;
      logic [2:0] prescale;
      logic dir_a;
      logic dir_b;
   } tmr_ctrl_s;
   typedef struct packed {
      logic at_top;
      logic at_wrap;
      logic fast_pwm;
      logic fixed_top;
      logic [15:0] top;
   } tmr_tim_s;
endpackage : tmr_pkg

// ==== logic/tmr_prescaler.sv ====
// tmr_prescaler: turns the I/O clock into timer ticks
// assumes: one clock, synchronous reset, select from a register
`timescale 1ns/1ps
module tmr_prescaler (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] sel_i,
   output logic tick_o
);
   logic [10:0] div_reg;
   logic [10:0] div_next;
   logic [10:0] limit;

   // ------------------------------------------------------------
   // divide selection
   // ------------------------------------------------------------
   assign limit = (sel_i == tmr_pkg::PRE_DIV8) ? tmr_pkg::DIV_8 :
                  (sel_i == tmr_pkg::PRE_DIV64) ? tmr_pkg::DIV_64 :
                  (sel_i == tmr_pkg::PRE_DIV256) ? tmr_pkg::DIV_256 :
                  (sel_i == tmr_pkg::PRE_DIV1024) ? tmr_pkg::DIV_1024 : 11'h001;
   assign div_next = (div_reg + 11'h001 >= limit) ? 11'h000 : div_reg + 11'h001;
   assign tick_o = (sel_i == tmr_pkg::PRE_DIV1) ||
                   ((sel_i >= tmr_pkg::PRE_DIV8) && (sel_i <= tmr_pkg::PRE_DIV1024) &&
                    (div_reg + 11'h001 >= limit));

   always_ff @(posedge clk_i) begin
      if (rst_i || sel_i == tmr_pkg::PRE_STOP) begin
         div_reg <= 11'h000;
      end else begin
         div_reg <= div_next;
      end
   end
endmodule : tmr_prescaler

// ==== logic/tmr_out_unit.sv ====
// tmr_out_unit: one compare output latch and pin driver
// assumes: match and timing strobes come from tmr_timer16 on the same clock
`timescale 1ns/1ps
module tmr_out_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic match_i,
   input wire logic force_i,
   input wire logic [1:0] action_i,
   input wire logic dir_i,
   input wire tmr_pkg::tmr_tim_s tim_i,
   output logic pin_o,
   output logic pin_oe_o,
   output logic state_o
);
   logic oc_reg;
   logic oc_next;
   logic nonpwm_next;
   logic pwm_next;

   // ------------------------------------------------------------
   // action decode
   // ------------------------------------------------------------
   assign nonpwm_next = (action_i == tmr_pkg::ACT_TOGGLE) ? ~oc_reg :
                        (action_i == tmr_pkg::ACT_CLEAR) ? 1'b0 :
                        (action_i == tmr_pkg::ACT_SET) ? 1'b1 : oc_reg;
   // top-to-bottom restores polarity unless match at top holds it
   assign pwm_next = (match_i && !tim_i.at_top) ? (action_i == tmr_pkg::ACT_CLEAR) :
                     (tim_i.at_top && !match_i) ? (action_i == tmr_pkg::ACT_SET) :
                     (tim_i.at_top && match_i) ? (action_i == tmr_pkg::ACT_CLEAR) : oc_reg;
   // toggle in fast pwm only with compare a as top
   assign oc_next = (!tim_i.fast_pwm) ? (match_i ? nonpwm_next : oc_reg) :
                    (action_i[1]) ? pwm_next :
                    (action_i == tmr_pkg::ACT_TOGGLE && !tim_i.fixed_top && match_i) ? ~oc_reg : oc_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oc_reg <= 1'b0;
      end else if (force_i && !tim_i.fast_pwm) begin
         oc_reg <= nonpwm_next;
      end else if (tick_i) begin
         oc_reg <= oc_next;
      end
   end

   // pin always shows latch; direction drives only the output enable
   assign pin_o = oc_reg;
   assign pin_oe_o = dir_i;
   assign state_o = oc_reg;
endmodule : tmr_out_unit

// ==== logic/tmr_timer16.sv ====
// tmr_timer16: 16-bit timer with normal, clear-on-match and fast pwm modes
// assumes: classic wishbone slave on clk_i, synchronous active high reset
`timescale 1ns/1ps
module tmr_timer16 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   output logic compare_a_output_pin_o,
   output logic compare_a_output_pin_oe_o,
   output logic compare_b_output_pin_o,
   output logic compare_b_output_pin_oe_o
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] ctrl_reg;
   logic [15:0] counter_value_reg;
   logic [15:0] counter_value_next;
   logic [15:0] cmpa_active_reg;
   logic [15:0] cmpa_buf_reg;
   logic [15:0] cmpb_reg;
   logic [15:0] capture_value_reg;
   logic overflow_flag_reg;
   logic compare_a_flag_reg;
   logic compare_b_flag_reg;
   logic capture_flag_reg;
   logic block_reg;
   logic ack_reg;
   logic err_reg;
   logic [31:0] dat_reg;
   logic [31:0] rd_next;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic req;
   logic hit;
   logic wr;
   logic wr_ctrl;
   logic wr_count;
   logic wr_cmpa;
   logic wr_cmpb;
   logic wr_capt;
   logic wr_flags;
   logic [31:0] wmask;
   logic [31:0] wdat_ctrl;
   logic [15:0] wdat_count;
   logic [15:0] wdat_cmpa;
   logic [15:0] wdat_cmpb;
   logic [15:0] wdat_capt;
   logic [15:0] res_mask;

   assign req = cyc_i && stb_i && !ack_reg && !err_reg;
   assign hit = (adr_i[1:0] == 2'b00) && (adr_i <= tmr_pkg::ADDR_LAST);
   // write lands at the edge where the master samples ack high
   assign wr = cyc_i && stb_i && ack_reg && hit && we_i;
   assign wr_ctrl = wr && (adr_i == {1'b0, tmr_pkg::ADDR_CTRL});
   assign wr_count = wr && (adr_i == {1'b0, tmr_pkg::ADDR_COUNT});
   assign wr_cmpa = wr && (adr_i == {1'b0, tmr_pkg::ADDR_CMPA});
   assign wr_cmpb = wr && (adr_i == {1'b0, tmr_pkg::ADDR_CMPB});
   assign wr_capt = wr && (adr_i == tmr_pkg::ADDR_CAPT);
   assign wr_flags = wr && (adr_i == tmr_pkg::ADDR_FLAGS);
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign wdat_ctrl = (ctrl_reg & ~wmask) | (dat_i & wmask);
   assign wdat_count = (counter_value_reg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
   assign wdat_cmpa = ((cmpa_buf_reg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0])) & res_mask;
   assign wdat_cmpb = ((cmpb_reg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0])) & res_mask;
   assign wdat_capt = (capture_value_reg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);

   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   tmr_pkg::tmr_ctrl_s ctrl;
   tmr_pkg::tmr_wgm_e mode;

   assign ctrl.waveform_mode_select = ctrl_reg[tmr_pkg::CTRL_MODE_LSB +: 4];
   assign ctrl.compare_a_output_action = ctrl_reg[tmr_pkg::CTRL_ACTA_LSB +: 2];
   assign ctrl.compare_b_output_action = ctrl_reg[tmr_pkg::CTRL_ACTB_LSB +: 2];
   assign ctrl.prescale = ctrl_reg[tmr_pkg::CTRL_PRE_LSB +: 3];
   assign ctrl.dir_a = ctrl_reg[tmr_pkg::CTRL_DIRA_BIT];
   assign ctrl.dir_b = ctrl_reg[tmr_pkg::CTRL_DIRB_BIT];
   assign mode = tmr_pkg::tmr_wgm_e'(ctrl.waveform_mode_select);

   // ------------------------------------------------------------
   // top selection
   // ------------------------------------------------------------
   logic is_fast;
   logic is_ctc;
   logic top_is_cmpa;
   logic top_is_capt;
   logic [15:0] top_val;
   logic tick;
   tmr_pkg::tmr_tim_s tim;

   assign is_fast = (mode == tmr_pkg::WGM_FAST8) || (mode == tmr_pkg::WGM_FAST9) ||
                    (mode == tmr_pkg::WGM_FAST10) || (mode == tmr_pkg::WGM_FAST_CAPT) ||
                    (mode == tmr_pkg::WGM_FAST_CMPA);
   assign is_ctc = (mode == tmr_pkg::WGM_CTC_CMPA) || (mode == tmr_pkg::WGM_CTC_CAPT);
   assign top_is_cmpa = (mode == tmr_pkg::WGM_CTC_CMPA) || (mode == tmr_pkg::WGM_FAST_CMPA);
   assign top_is_capt = (mode == tmr_pkg::WGM_CTC_CAPT) || (mode == tmr_pkg::WGM_FAST_CAPT);
   assign top_val = (mode == tmr_pkg::WGM_FAST8) ? tmr_pkg::TOP_8BIT :
                    (mode == tmr_pkg::WGM_FAST9) ? tmr_pkg::TOP_9BIT :
                    (mode == tmr_pkg::WGM_FAST10) ? tmr_pkg::TOP_10BIT :
                    top_is_cmpa ? cmpa_active_reg :
                    top_is_capt ? capture_value_reg : tmr_pkg::CNT_MAX;
   assign res_mask = (mode == tmr_pkg::WGM_FAST8) ? tmr_pkg::TOP_8BIT :
                     (mode == tmr_pkg::WGM_FAST9) ? tmr_pkg::TOP_9BIT :
                     (mode == tmr_pkg::WGM_FAST10) ? tmr_pkg::TOP_10BIT : tmr_pkg::CNT_MAX;

   // ------------------------------------------------------------
   // match detection
   // ------------------------------------------------------------
   logic at_top;
   logic at_max;
   logic match_a;
   logic match_b;
   logic clear_cnt;
   logic ovf_set;
   logic cmpa_set;
   logic capt_set;
   logic force_a;
   logic force_b;
   logic force_a_reg;
   logic force_b_reg;

   // exact equality only: a top below the count is missed
   assign at_top = (counter_value_reg == top_val) && !block_reg && (is_fast || is_ctc);
   assign at_max = (counter_value_reg == tmr_pkg::CNT_MAX);
   assign match_a = (counter_value_reg == cmpa_active_reg) && !block_reg;
   assign match_b = (counter_value_reg == cmpb_reg) && !block_reg;
   assign clear_cnt = at_top;
   // overflow at wrap in normal/ctc, at top in fast pwm
   assign ovf_set = tick && (is_fast ? at_top : at_max);
   assign cmpa_set = tick && match_a;
   assign capt_set = tick && top_is_capt && at_top;
   assign force_a = wr_ctrl && sel_i[1] && dat_i[tmr_pkg::CTRL_FORCEA_BIT];
   assign force_b = wr_ctrl && sel_i[1] && dat_i[tmr_pkg::CTRL_FORCEB_BIT];

   assign tim.at_top = at_top;
   assign tim.at_wrap = at_max;
   assign tim.fast_pwm = is_fast;
   assign tim.fixed_top = (mode != tmr_pkg::WGM_FAST_CMPA);
   assign tim.top = top_val;

   assign counter_value_next = clear_cnt ? tmr_pkg::CNT_BOTTOM : counter_value_reg + 16'h0001;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   assign rd_next = (adr_i == {1'b0, tmr_pkg::ADDR_CTRL}) ? ctrl_reg :
                    (adr_i == {1'b0, tmr_pkg::ADDR_COUNT}) ? {16'h0000, counter_value_reg} :
                    (adr_i == {1'b0, tmr_pkg::ADDR_CMPA}) ? {16'h0000, cmpa_buf_reg} :
                    (adr_i == {1'b0, tmr_pkg::ADDR_CMPB}) ? {16'h0000, cmpb_reg} :
                    (adr_i == tmr_pkg::ADDR_CAPT) ? {16'h0000, capture_value_reg} :
                    {28'h0000000, capture_flag_reg, compare_b_flag_reg, compare_a_flag_reg,
                     overflow_flag_reg};

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   tmr_prescaler u_pre (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(ctrl.prescale),
      .tick_o(tick)
   );

   tmr_out_unit u_out_a (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .match_i(match_a),
      .force_i(force_a_reg),
      .action_i(ctrl.compare_a_output_action),
      .dir_i(ctrl.dir_a),
      .tim_i(tim),
      .pin_o(compare_a_output_pin_o),
      .pin_oe_o(compare_a_output_pin_oe_o),
      .state_o()
   );

   tmr_out_unit u_out_b (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .match_i(match_b),
      .force_i(force_b_reg),
      .action_i(ctrl.compare_b_output_action),
      .dir_i(ctrl.dir_b),
      .tim_i(tim),
      .pin_o(compare_b_output_pin_o),
      .pin_oe_o(compare_b_output_pin_oe_o),
      .state_o()
   );

   // ------------------------------------------------------------
   // counter and blocking
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_value_reg <= tmr_pkg::CNT_BOTTOM;
      end else if (wr_count) begin
         counter_value_reg <= wdat_count;
      end else if (tick) begin
         counter_value_reg <= counter_value_next;
      end
   end

   // a counter write blocks matches until one tick has passed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         block_reg <= 1'b0;
      end else if (wr_count) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end

   // force strobe waits a cycle so the newly written action applies
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_a_reg <= 1'b0;
         force_b_reg <= 1'b0;
      end else begin
         force_a_reg <= force_a;
         force_b_reg <= force_b;
      end
   end

   // ------------------------------------------------------------
   // control and compare registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= tmr_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= wdat_ctrl & 32'h0000_1FFF;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmpa_buf_reg <= tmr_pkg::CNT_BOTTOM;
         cmpb_reg <= tmr_pkg::CNT_BOTTOM;
         capture_value_reg <= tmr_pkg::CNT_BOTTOM;
      end else begin
         if (wr_cmpa) begin
            cmpa_buf_reg <= wdat_cmpa;
         end
         if (wr_cmpb) begin
            cmpb_reg <= wdat_cmpb;
         end
         if (wr_capt) begin
            capture_value_reg <= wdat_capt;
         end
      end
   end

   // buffered in fast pwm, direct otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmpa_active_reg <= tmr_pkg::CNT_BOTTOM;
      end else if (!is_fast && wr_cmpa) begin
         cmpa_active_reg <= wdat_cmpa;
      end else if (!is_fast) begin
         cmpa_active_reg <= cmpa_buf_reg;
      end else if (tick && at_top) begin
         cmpa_active_reg <= cmpa_buf_reg;
      end
   end

   // ------------------------------------------------------------
   // flags: hardware set wins over write-one-to-clear
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow_flag_reg <= 1'b0;
         compare_a_flag_reg <= 1'b0;
         compare_b_flag_reg <= 1'b0;
         capture_flag_reg <= 1'b0;
      end else begin
         overflow_flag_reg <= ovf_set | (overflow_flag_reg &
                              ~(wr_flags && sel_i[0] && dat_i[tmr_pkg::FLAG_OVF_BIT]));
         compare_a_flag_reg <= cmpa_set | (compare_a_flag_reg &
                               ~(wr_flags && sel_i[0] && dat_i[tmr_pkg::FLAG_CMPA_BIT]));
         compare_b_flag_reg <= (tick && match_b) | (compare_b_flag_reg &
                               ~(wr_flags && sel_i[0] && dat_i[tmr_pkg::FLAG_CMPB_BIT]));
         capture_flag_reg <= capt_set | (capture_flag_reg &
                             ~(wr_flags && sel_i[0] && dat_i[tmr_pkg::FLAG_CAPT_BIT]));
      end
   end

   // ------------------------------------------------------------
   // wishbone answer
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req && hit;
         err_reg <= req && !hit;
         if (req && hit && !we_i) begin
            dat_reg <= rd_next;
         end
      end
   end

   assign ack_o = ack_reg;
   assign err_o = err_reg;
   assign dat_o = dat_reg;
endmodule : tmr_timer16

// ==== tb/tmr_timer16_properties.sv ====
// tmr_chk: port-level properties of tmr_timer16
// assumes: bound to tmr_timer16, single clock, synchronous reset
`timescale 1ns/1ps
module tmr_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic err_o,
   input wire logic compare_a_output_pin_o,
   input wire logic compare_a_output_pin_oe_o,
   input wire logic compare_b_output_pin_o,
   input wire logic compare_b_output_pin_oe_o
);
   logic dir_a_q;
   logic dir_b_q;
   logic [1:0] act_a_q;
   wire mapped = adr_i <= 5'h14 && adr_i[1:0] == 2'h0;
   wire ctrl_wr = cyc_i && stb_i && we_i && ack_o && adr_i == 5'h00;
   // shadow of both direction bits and the compare a action field
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_a_q <= 1'b0;
         dir_b_q <= 1'b0;
         act_a_q <= 2'h0;
      end else if (ctrl_wr) begin
         if (sel_i[1]) dir_a_q <= dat_i[11];
         if (sel_i[1]) dir_b_q <= dat_i[12];
         if (sel_i[0]) act_a_q <= dat_i[5:4];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_s;
      cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   ack_next_a: assert property (req_s ##0 mapped |=> ack_o && !err_o) else $error("missing ack");
   err_next_a: assert property (req_s ##0 !mapped |=> err_o && !ack_o) else $error("missing err");
   ack_pulse_a: assert property (ack_o || err_o |=> !ack_o && !err_o) else $error("answer too long");
   idle_quiet_a: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o) else $error("answer unasked");
   read_hold_a: assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
   dir_a_a: assert property (compare_a_output_pin_oe_o == dir_a_q) else $error("pin a enable");
   dir_b_a: assert property (compare_b_output_pin_oe_o == dir_b_q) else $error("pin b enable");
   act_none_a: assert property (act_a_q == 2'h0 |=> $stable(compare_a_output_pin_o)) else $error("pin moved");
endmodule : tmr_chk
bind tmr_timer16 tmr_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
   .err_o, .compare_a_output_pin_o, .compare_a_output_pin_oe_o, .compare_b_output_pin_o, .compare_b_output_pin_oe_o);

// ==== tb/tb.sv ====
// tb: self-checking bench for tmr_timer16 over wishbone
// assumes: tmr_pkg and the checker file compiled first
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd;
   logic ack_o, err_o, pa, pa_oe, pb, pb_oe, er;
   int n_errors = 0;
   int checks_done = 0;
   int per, hi, h2;
   always #4 clk_i = ~clk_i;
   tmr_timer16 dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
      .compare_a_output_pin_o(pa), .compare_a_output_pin_oe_o(pa_oe), .compare_b_output_pin_o(pb),
      .compare_b_output_pin_oe_o(pb_oe));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
      rd = dat_o;
      er = err_o;
      if (n >= 50) chk(32'h1, 32'h0);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : bus
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   // stop, zero the count, clear flags, load compare a, then start
   task automatic cfg(input logic [31:0] c, input logic [31:0] ca);
      bus(1'b1, 5'h00, 32'h0);
      bus(1'b1, 5'h04, 32'h0);
      bus(1'b1, 5'h14, 32'hF);
      bus(1'b1, 5'h08, ca);
      bus(1'b1, 5'h00, c);
   endtask : cfg
   // one period of pin a, rising edge to rising edge
   task automatic meas();
      int n = 0;
      while (pa !== 1'b0 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      while (pa !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      per = 0;
      hi = 0;
      while (pa === 1'b1 && per < 3000) begin
         @(posedge clk_i);
         per++;
         hi++;
      end
      while (pa === 1'b0 && per < 3000) begin
         @(posedge clk_i);
         per++;
      end
   endtask : meas
   task automatic give_verdict();
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #(30000 * 8);
      n_errors++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(5'h00, 32'h0);
      rdc(5'h14, 32'h0);
      bus(1'b0, 5'h18, 32'h0);
      chk(er, 1'b1);
      bus(1'b0, 5'h02, 32'h0);
      chk(er, 1'b1);
      cfg(32'h0, 32'h0);
      bus(1'b1, 5'h04, 32'hFFF0);
      bus(1'b1, 5'h00, 32'h100);
      repeat (30) @(posedge clk_i);
      bus(1'b1, 5'h00, 32'h0);
      // 33 ticks at divide-by-one, wrapped past zero
      rdc(5'h04, 32'h11);
      chk({rd[31:6], 6'h0}, 32'h0);
      bus(1'b0, 5'h14, 32'h0);
      chk(rd & 32'h1, 32'h1);
      // force b with action set and direction out
      bus(1'b1, 5'h00, 32'h50C0);
      repeat (2) @(posedge clk_i);
      chk(pb, 1'b1);
      chk(pb_oe, 1'b1);
      cfg(32'h0914, 32'h3);
      meas();
      chk(per, 8);
      chk(hi, 4);
      chk(pa_oe, 1'b1);
      chk(pb_oe, 1'b0);
      bus(1'b0, 5'h14, 32'h0);
      chk(rd & 32'h3, 32'h2);
      cfg(32'h0A14, 32'h3);
      meas();
      chk(per, 64);
      cfg(32'h091F, 32'h7);
      meas();
      chk(per, 16);
      chk(hi, 8);
      bus(1'b0, 5'h14, 32'h0);
      chk(rd & 32'h3, 32'h3);
      bus(1'b1, 5'h10, 32'h9);
      cfg(32'h091C, 32'h3);
      meas();
      chk(per, 20);
      bus(1'b0, 5'h14, 32'h0);
      chk(rd & 32'hB, 32'hA);
      cfg(32'h092E, 32'h3);
      meas();
      h2 = hi;
      chk(per, 10);
      cfg(32'h093E, 32'h3);
      meas();
      chk(per, 10);
      chk(hi + h2, 10);
      for (int m = 5; m <= 7; m++) begin
         cfg(32'h0920 + m, 32'h10);
         meas();
         chk(per, 32'h8 << m);
      end
      bus(1'b1, 5'h08, 32'hFFFF);
      rdc(5'h08, 32'h03FF);
      give_verdict();
   end
endmodule : tb
